// *** rtl/do_router_regs.svh ***
// constants for the digital output router: codes, resets, timing
// assumes inclusion by the package only
`ifndef DO_ROUTER_REGS_SVH
`define DO_ROUTER_REGS_SVH
`define N_OUT 5
`define OP_W 3
`define SRC_W 6
`define OP_CODE_MAX 3'h6
`define SRC_OFF 6'h00
`define SRC_ON 6'h01
`define SRC_IEV0 6'h02
`define SRC_MV1 6'h0E
`define SRC_MV2 6'h0F
`define SRC_DI0 6'h12
`define SRC_ICT0 6'h1A
`define SRC_CDI0 6'h22
`define SRC_MANUAL 6'h26
`define SRC_READY 6'h27
`define SRC_RSP 6'h28
`define SRC_AT 6'h29
`define SRC_RAMP 6'h2A
`define SRC_ALARM 6'h2C
`define SRC_PVALM 6'h2D
`define SRC_MODEKEY 6'h2F
`define SRC_EVT1FB 6'h30
`define SRC_CTRL1FB 6'h31
`define RST_SRC_C1A 6'h0E
`define RST_SRC_C2A 6'h0F
`define RST_SRC_E1A 6'h02
`define RST_SRC_E2A 6'h03
`define RST_SRC_E3A 6'h04
`define TP_UNIT_1S 2'h0
`define TP_UNIT_0P5 2'h1
`define TP_UNIT_0P25 2'h2
`define TP_UNIT_0P1 2'h3
`define TP_STEPS_1S 10'h3E8
`define TP_STEPS_0P5 10'h1F4
`define TP_STEPS_0P25 10'h0FA
`define TP_STEPS_0P1 10'h064
`define TP_DUTY_FULL 10'h3E8
`define SYS_CLK_PERIOD_NS 8
`define TP_MS_NS 1000000
`define TP_STRETCH_NUM 1024
`define TP_STRETCH_DEN 1000
`endif

// *** rtl/do_router_pkg.sv ***
// types for the digital output router
// assumes the constants header sits beside it
package do_router_pkg;
`include "do_router_regs.svh"
    typedef enum logic [2:0] {
        OP_DEFAULT = 3'h0,
        OP_MV1 = 3'h1,
        OP_MV2 = 3'h2,
        OP_F1 = 3'h3,
        OP_F2 = 3'h4,
        OP_F3 = 3'h5,
        OP_F4 = 3'h6
    } op_type_e;
    typedef struct packed {
        op_type_e op;
        logic [3:0][5:0] src;
    } out_cfg_s;
    typedef struct packed {
        logic manual_mode;
        logic ready_mode;
        logic remote_setpoint_mode;
        logic autotuning_active;
        logic sp_ramp_active;
        logic any_alarm;
        logic pv_alarm;
    } ctrl_status_s;
endpackage

// *** rtl/out_eval.sv ***
// one output: source selection for inputs a to d and the bit function
// assumes the source vector holds zero at every undefined code
`timescale 1ns/1ps
module out_eval
    import do_router_pkg::*;
(
    input wire out_cfg_s cfg,
    input wire logic [63:0] src_vec,
    input wire logic default_val,
    input wire logic mv1,
    input wire logic mv2,
    output logic result,
    output logic [3:0] in_bits
);
    logic a;
    logic b;
    logic c;
    logic d;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            in_bits[i] = src_vec[cfg.src[i]];
        end
        a = in_bits[0];
        b = in_bits[1];
        c = in_bits[2];
        d = in_bits[3];
        case (cfg.op)
            OP_DEFAULT: result = default_val;
            OP_MV1: result = mv1;
            OP_MV2: result = mv2;
            OP_F1: result = (a & b) | (c & d);
            OP_F2: result = (a | b) & (c | d);
            OP_F3: result = a | b | c | d;
            OP_F4: result = a & b & c & d;
            default: result = 1'b0;
        endcase
    end
endmodule

// *** rtl/tp_pwm.sv ***
// one time-proportional channel stepping on a shared millisecond tick
// assumes ms_tick is a one-cycle pulse from the same clock
`timescale 1ns/1ps
module tp_pwm
    import do_router_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ms_tick,
    input wire logic [1:0] unit_sel,
    input wire logic [6:0] cycle_s,
    input wire logic [9:0] duty,
    output logic tp_out
);
    logic [6:0] sub_reg;
    logic [6:0] sub_next;
    logic [9:0] pos_reg;
    logic [9:0] pos_next;
    logic out_reg;
    logic out_next;
    logic [9:0] steps;
    logic [9:0] on_steps;
    logic [9:0] duty_c;
    logic [6:0] step_len;
    always_comb
    begin
        duty_c = (duty > `TP_DUTY_FULL) ? `TP_DUTY_FULL : duty;
        step_len = 7'h01;
        // per-mille steps, step of cycle ms
        // fixed cycles in 1 ms steps
        case (unit_sel)
            `TP_UNIT_1S:
            begin
                steps = `TP_STEPS_1S;
                on_steps = duty_c;
                step_len = (cycle_s == 7'h00) ? 7'h01 : cycle_s;
            end
            `TP_UNIT_0P5:
            begin
                steps = `TP_STEPS_0P5;
                on_steps = duty_c >> 1;
            end
            `TP_UNIT_0P25:
            begin
                steps = `TP_STEPS_0P25;
                on_steps = duty_c >> 2;
            end
            default:
            begin
                steps = `TP_STEPS_0P1;
                on_steps = duty_c / 10'h00A;
            end
        endcase
        sub_next = sub_reg;
        pos_next = pos_reg;
        if (ms_tick)
        begin
            if (sub_reg + 7'h01 >= step_len)
            begin
                sub_next = 7'h00;
                pos_next = (pos_reg + 10'h001 >= steps) ? 10'h000
                    : pos_reg + 10'h001;
            end
            else
            begin
                sub_next = sub_reg + 7'h01;
            end
        end
        out_next = pos_reg < on_steps;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sub_reg <= 7'h00;
            pos_reg <= 10'h000;
            out_reg <= 1'b0;
        end
        else
        begin
            sub_reg <= sub_next;
            pos_reg <= pos_next;
            out_reg <= out_next;
        end
    end
    assign tp_out = out_reg;
endmodule

// *** rtl/do_router.sv ***
// digital output router: two control and three event outputs
// assumes internal status inputs share sys_clk; pins are synchronised here
// Notes on behaviour
// - 1s unit resolves on-time in 1/1000 cycle
// - fixed cycles resolve in 1 ms steps
// - realised cycle about 2.4 percent long
// - op type 0 default, 1 mv1, 2 mv2
// - type 3 gives (a and b) or (c and d)
// - type 4 gives (a or b) and (c or d)
// - type 5 on when any input on
// - type 6 on when all inputs on
// - default routes mv1 and mv2 to controls
// - default routes events 1-3 to event outputs
// - mv1 on/off or heat, mv2 cool
// - op type writable only on usable outputs
// - and/or follow plain truth tables
// - codes 0,1 constant; 2-9 internal events
// - 14,15 mv; 18-21 digital inputs
// - contacts, comm inputs and modes by code
// - 44 any alarm, 45 pv alarm
// - 47 mode key, 48/49 output feedback
// - reset source defaults per output input a
// - sources writable only under bit functions
`timescale 1ns/1ps
module do_router
    import do_router_pkg::*;
#(
    parameter int MS_TICK_CYCLES = (`TP_MS_NS * `TP_STRETCH_NUM
        / `TP_STRETCH_DEN) / `SYS_CLK_PERIOD_NS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] internal_event,
    input wire logic [3:0] digital_input,
    input wire logic [4:0] internal_contact,
    input wire logic [3:0] comm_input,
    input wire ctrl_status_s ctrl_status,
    input wire logic mode_key,
    input wire logic mv1_onoff_mode,
    input wire logic mv1_onoff_state,
    input wire logic [9:0] mv1_duty,
    input wire logic [9:0] mv2_duty,
    input wire logic [1:0] tp_unit_select_1,
    input wire logic [1:0] tp_unit_select_2,
    input wire logic [6:0] tp_cycle_1,
    input wire logic [6:0] tp_cycle_2,
    input wire logic [1:0] ctrl_out_switching,
    input wire logic [2:0] evt_out_fitted,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_out_sel,
    input wire logic [2:0] cfg_field,
    input wire logic [5:0] cfg_data,
    output logic [1:0] ctrl_out,
    output logic [2:0] evt_out,
    output logic primary_manip_output,
    output logic secondary_manip_output,
    output logic cfg_accept,
    output logic cfg_reject
);
    localparam int TICK_W = $clog2(MS_TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);
    localparam out_cfg_s CFG_RST [`N_OUT] = '{
        '{OP_DEFAULT, {`SRC_OFF, `SRC_OFF, `SRC_OFF, `RST_SRC_C1A}},
        '{OP_DEFAULT, {`SRC_OFF, `SRC_OFF, `SRC_OFF, `RST_SRC_C2A}},
        '{OP_DEFAULT, {`SRC_OFF, `SRC_OFF, `SRC_OFF, `RST_SRC_E1A}},
        '{OP_DEFAULT, {`SRC_OFF, `SRC_OFF, `SRC_OFF, `RST_SRC_E2A}},
        '{OP_DEFAULT, {`SRC_OFF, `SRC_OFF, `SRC_OFF, `RST_SRC_E3A}}
    };

    // pin synchronisers
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [3:0] di_sync;
    logic key_sync;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
        end
        else
        begin
            pin_s1_reg <= {mode_key, digital_input};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign di_sync = pin_s2_reg[3:0];
    assign key_sync = pin_s2_reg[4];

    // millisecond tick, stretched
    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic ms_tick;
    always_comb
    begin
        ms_tick = (tick_reg == TICK_LAST);
        tick_next = ms_tick ? '0 : tick_reg + 1'b1;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            tick_reg <= '0;
        end
        else
        begin
            tick_reg <= tick_next;
        end
    end

    // time-proportional channels
    logic tp1;
    logic tp2;
    tp_pwm u_tp1 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ms_tick(ms_tick),
        .unit_sel(tp_unit_select_1),
        .cycle_s(tp_cycle_1),
        .duty(mv1_duty),
        .tp_out(tp1)
    );
    tp_pwm u_tp2 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ms_tick(ms_tick),
        .unit_sel(tp_unit_select_2),
        .cycle_s(tp_cycle_2),
        .duty(mv2_duty),
        .tp_out(tp2)
    );

    // manipulated outputs
    logic mv1_reg;
    logic mv1_next;
    logic mv2_reg;
    logic mv2_next;
    always_comb
    begin
        // mv1 on/off or tp, mv2 tp
        mv1_next = mv1_onoff_mode ? mv1_onoff_state : tp1;
        mv2_next = tp2;
    end

    // configuration store with write gating
    out_cfg_s cfg_reg [`N_OUT];
    out_cfg_s cfg_next [`N_OUT];
    logic [`N_OUT-1:0] usable;
    logic acc_next;
    logic rej_next;
    logic acc_reg;
    logic rej_reg;
    logic is_fn;
    always_comb
    begin
        usable = {evt_out_fitted, ctrl_out_switching};
        cfg_next = cfg_reg;
        acc_next = 1'b0;
        rej_next = 1'b0;
        is_fn = 1'b0;
        if (cfg_wr)
        begin
            rej_next = 1'b1;
            if (cfg_out_sel < 3'(`N_OUT))
            begin
                is_fn = cfg_reg[cfg_out_sel].op >= OP_F1;
                if (cfg_field == 3'h0 && usable[cfg_out_sel]
                    && cfg_data <= 6'(`OP_CODE_MAX))
                begin
                    cfg_next[cfg_out_sel].op = op_type_e'(cfg_data[2:0]);
                    acc_next = 1'b1;
                    rej_next = 1'b0;
                end
                else if (cfg_field >= 3'h1 && cfg_field <= 3'h4
                    && usable[cfg_out_sel] && is_fn)
                begin
                    cfg_next[cfg_out_sel].src[cfg_field[1:0] - 2'h1] =
                        cfg_data;
                    acc_next = 1'b1;
                    rej_next = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cfg_reg <= CFG_RST;
            acc_reg <= 1'b0;
            rej_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            acc_reg <= acc_next;
            rej_reg <= rej_next;
        end
    end

    // source vector
    logic [63:0] src_vec;
    logic [1:0] ctrl_reg;
    logic [1:0] ctrl_next;
    logic [2:0] evt_reg;
    logic [2:0] evt_next;
    always_comb
    begin
        src_vec = 64'h0;
        src_vec[`SRC_ON] = 1'b1;
        src_vec[`SRC_IEV0 +: 8] = internal_event;
        src_vec[`SRC_MV1] = mv1_reg;
        src_vec[`SRC_MV2] = mv2_reg;
        src_vec[`SRC_DI0 +: 4] = di_sync;
        src_vec[`SRC_ICT0 +: 5] = internal_contact;
        src_vec[`SRC_CDI0 +: 4] = comm_input;
        src_vec[`SRC_MANUAL] = ctrl_status.manual_mode;
        src_vec[`SRC_READY] = ctrl_status.ready_mode;
        src_vec[`SRC_RSP] = ctrl_status.remote_setpoint_mode;
        src_vec[`SRC_AT] = ctrl_status.autotuning_active;
        src_vec[`SRC_RAMP] = ctrl_status.sp_ramp_active;
        src_vec[`SRC_ALARM] = ctrl_status.any_alarm;
        src_vec[`SRC_PVALM] = ctrl_status.pv_alarm;
        src_vec[`SRC_MODEKEY] = key_sync;
        src_vec[`SRC_EVT1FB] = evt_reg[0];
        src_vec[`SRC_CTRL1FB] = ctrl_reg[0];
    end

    // per-output evaluation
    logic [`N_OUT-1:0] dflt;
    logic [`N_OUT-1:0] res;
    logic [3:0] in_bits [`N_OUT];
    // events 1-3 default to event outputs
    assign dflt = {internal_event[2:0], mv2_reg, mv1_reg};
    genvar g;
    generate
        for (g = 0; g < `N_OUT; g++)
        begin : g_out
            out_eval u_eval (
                .cfg(cfg_reg[g]),
                .src_vec(src_vec),
                .default_val(dflt[g]),
                .mv1(mv1_reg),
                .mv2(mv2_reg),
                .result(res[g]),
                .in_bits(in_bits[g])
            );
        end
    endgenerate
    always_comb
    begin
        ctrl_next = res[1:0];
        evt_next = res[4:2];
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mv1_reg <= 1'b0;
            mv2_reg <= 1'b0;
            ctrl_reg <= 2'h0;
            evt_reg <= 3'h0;
        end
        else
        begin
            mv1_reg <= mv1_next;
            mv2_reg <= mv2_next;
            ctrl_reg <= ctrl_next;
            evt_reg <= evt_next;
        end
    end
    assign ctrl_out = ctrl_reg;
    assign evt_out = evt_reg;
    assign primary_manip_output = mv1_reg;
    assign secondary_manip_output = mv2_reg;
    assign cfg_accept = acc_reg;
    assign cfg_reject = rej_reg;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_op_write(int k);
        cfg_wr && cfg_field == 3'h0 && cfg_out_sel == 3'(k)
            && cfg_data <= 6'(`OP_CODE_MAX);
    endsequence
    property p_tick_period;
        ms_tick |=> !ms_tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("ms tick not a single pulse");
    property p_dflt_c1;
        cfg_reg[0].op == OP_DEFAULT |=> ctrl_out[0] == $past(mv1_reg);
    endproperty
    a_dflt_c1: assert property (p_dflt_c1)
        else $error("control 1 default not mv1");
    property p_dflt_e2;
        cfg_reg[3].op == OP_DEFAULT |=> evt_out[1] == $past(internal_event[1]);
    endproperty
    a_dflt_e2: assert property (p_dflt_e2)
        else $error("event 2 default not event 2");
    property p_mv2_sel;
        cfg_reg[2].op == OP_MV2 |=> evt_out[0] == $past(mv2_reg);
    endproperty
    a_mv2_sel: assert property (p_mv2_sel)
        else $error("mv2 selection wrong");
    property p_fn1;
        cfg_reg[0].op == OP_F1 |=> ctrl_out[0] == $past(
            (in_bits[0][0] & in_bits[0][1]) | (in_bits[0][2] & in_bits[0][3]));
    endproperty
    a_fn1: assert property (p_fn1)
        else $error("function 1 wrong");
    property p_fn2;
        cfg_reg[1].op == OP_F2 |=> ctrl_out[1] == $past(
            (in_bits[1][0] | in_bits[1][1]) & (in_bits[1][2] | in_bits[1][3]));
    endproperty
    a_fn2: assert property (p_fn2)
        else $error("function 2 wrong");
    property p_fn3;
        cfg_reg[4].op == OP_F3 |=> evt_out[2] == $past(|in_bits[4]);
    endproperty
    a_fn3: assert property (p_fn3)
        else $error("function 3 wrong");
    property p_fn4;
        cfg_reg[2].op == OP_F4 |=> evt_out[0] == $past(&in_bits[2]);
    endproperty
    a_fn4: assert property (p_fn4)
        else $error("function 4 wrong");
    property p_op_gate;
        s_op_write(0) ##0 !ctrl_out_switching[0]
            |=> cfg_reject && $stable(cfg_reg[0].op);
    endproperty
    a_op_gate: assert property (p_op_gate)
        else $error("op type written on unusable output");
    property p_src_gate;
        cfg_wr && cfg_out_sel == 3'h2 && cfg_field == 3'h1
            && cfg_reg[2].op < OP_F1 |=> cfg_reject ##0 $stable(cfg_reg[2]);
    endproperty
    a_src_gate: assert property (p_src_gate)
        else $error("source written without bit function");
    property p_undef;
        cfg_reg[3].src[0] inside {[6'h0A:6'h0D], 6'h10, 6'h11,
            [6'h16:6'h19], [6'h1F:6'h21], 6'h2B, 6'h2E, [6'h32:6'h3F]}
            |-> !in_bits[3][0];
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined source not off");
    property p_feedback;
        cfg_reg[3].src[0] == `SRC_CTRL1FB |-> in_bits[3][0] == ctrl_out[0];
    endproperty
    a_feedback: assert property (p_feedback)
        else $error("feedback not registered output");
    property p_const_on;
        cfg_reg[3].src[0] == `SRC_ON |-> in_bits[3][0];
    endproperty
    a_const_on: assert property (p_const_on)
        else $error("constant on source not on");
endmodule

// *** bench/out_driver_model.sv ***
// far-side model: relay and voltage pulse drivers on the outputs
// assumes outputs are registered levels on sys_clk
`timescale 1ns/1ps
module out_driver_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] ctrl_out,
    input wire logic [2:0] evt_out,
    input wire logic count_clr,
    output logic [4:0] pin_level,
    output logic [15:0] on_count
);
    // drivers latch the level, on-time counted for control output 1
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || count_clr)
            on_count <= 16'h0000;
        else
            on_count <= on_count + 16'(ctrl_out[0]);
        pin_level <= {evt_out, ctrl_out};
    end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the digital output router
// assumes the router and its package are compiled before it
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_top;
    import do_router_pkg::*;
    localparam int TICK = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] internal_event = 8'h00;
    logic [3:0] digital_input = 4'h0;
    logic [4:0] internal_contact = 5'h00;
    logic [3:0] comm_input = 4'h0;
    ctrl_status_s ctrl_status = '0;
    logic mode_key = 1'b0;
    logic mv1_onoff_mode = 1'b1;
    logic mv1_onoff_state = 1'b0;
    logic [9:0] mv1_duty = 10'h000;
    logic [9:0] mv2_duty = 10'h000;
    logic [1:0] tp_unit_select_1 = 2'h0;
    logic [1:0] tp_unit_select_2 = 2'h0;
    logic [6:0] tp_cycle_1 = 7'h01;
    logic [6:0] tp_cycle_2 = 7'h01;
    logic [1:0] ctrl_out_switching = 2'h3;
    logic [2:0] evt_out_fitted = 3'h7;
    logic cfg_wr = 1'b0;
    logic [2:0] cfg_out_sel = 3'h0;
    logic [2:0] cfg_field = 3'h0;
    logic [5:0] cfg_data = 6'h00;
    logic count_clr = 1'b0;
    logic [1:0] ctrl_out;
    logic [2:0] evt_out;
    logic primary_manip_output;
    logic secondary_manip_output;
    logic cfg_accept;
    logic cfg_reject;
    logic [15:0] on_count;
    int num_errors = 0;
    int samples_checked = 0;

    always #4 sys_clk = ~sys_clk;

    do_router #(.MS_TICK_CYCLES(TICK)) do_router_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .internal_event(internal_event),
        .digital_input(digital_input), .internal_contact(internal_contact),
        .comm_input(comm_input), .ctrl_status(ctrl_status),
        .mode_key(mode_key), .mv1_onoff_mode(mv1_onoff_mode),
        .mv1_onoff_state(mv1_onoff_state), .mv1_duty(mv1_duty),
        .mv2_duty(mv2_duty), .tp_unit_select_1(tp_unit_select_1),
        .tp_unit_select_2(tp_unit_select_2), .tp_cycle_1(tp_cycle_1),
        .tp_cycle_2(tp_cycle_2), .ctrl_out_switching(ctrl_out_switching),
        .evt_out_fitted(evt_out_fitted), .cfg_wr(cfg_wr),
        .cfg_out_sel(cfg_out_sel), .cfg_field(cfg_field),
        .cfg_data(cfg_data), .ctrl_out(ctrl_out), .evt_out(evt_out),
        .primary_manip_output(primary_manip_output),
        .secondary_manip_output(secondary_manip_output),
        .cfg_accept(cfg_accept), .cfg_reject(cfg_reject));

    out_driver_model out_driver_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .ctrl_out(ctrl_out), .evt_out(evt_out), .count_clr(count_clr),
        .pin_level(), .on_count(on_count));

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // one write, answer judged one cycle later
    task automatic cfg(input logic [2:0] sel, input logic [2:0] fld,
        input logic [5:0] dat, input logic ok);
        cfg_out_sel = sel;
        cfg_field = fld;
        cfg_data = dat;
        cfg_wr = 1'b1;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        `CHK("cfg_accept", ok, cfg_accept)
        `CHK("cfg_reject", !ok, cfg_reject)
        @(negedge sys_clk);
    endtask

    function automatic logic defined_src(input int c);
        return (c >= 1 && c <= 9) || c == 14 || c == 15 ||
            (c >= 18 && c <= 21) || (c >= 26 && c <= 30) ||
            (c >= 34 && c <= 42) || c == 44 || c == 45 ||
            (c >= 47 && c <= 49);
    endfunction

    task automatic test_defaults();
        internal_event = 8'h05;
        mv1_onoff_state = 1'b1;
        settle(4);
        `CHK("ctrl_out", 2'h1, ctrl_out)
        `CHK("evt_out", 3'h5, evt_out)
        for (int i = 0; i < 5; i++)
            cfg(3'(i), 3'h0, 6'h05, 1'b1);
        internal_event = 8'h02;
        settle(4);
        `CHK("ctrl_out", 2'h1, ctrl_out)
        `CHK("evt_out", 3'h2, evt_out)
    endtask

    task automatic test_refusals();
        cfg(3'h4, 3'h1, 6'h02, 1'b1);
        cfg(3'h5, 3'h0, 6'h01, 1'b0);
        cfg(3'h0, 3'h5, 6'h01, 1'b0);
        cfg(3'h0, 3'h0, 6'h07, 1'b0);
        ctrl_out_switching = 2'h0;
        cfg(3'h0, 3'h0, 6'h03, 1'b0);
        cfg(3'h1, 3'h0, 6'h03, 1'b0);
        ctrl_out_switching = 2'h3;
        evt_out_fitted = 3'h3;
        cfg(3'h4, 3'h0, 6'h03, 1'b0);
        evt_out_fitted = 3'h7;
        cfg(3'h1, 3'h0, 6'h01, 1'b1);
        settle(4);
        `CHK("ctrl_out2", 1'b1, ctrl_out[1])
        cfg(3'h1, 3'h0, 6'h02, 1'b1);
        settle(4);
        `CHK("ctrl_out2", 1'b0, ctrl_out[1])
        cfg(3'h2, 3'h0, 6'h00, 1'b1);
        cfg(3'h2, 3'h1, 6'h02, 1'b0);
    endtask

    task automatic test_bitfunc();
        logic [3:0] v;
        logic e;
        for (int op = 3; op <= 6; op++)
        begin
            cfg(3'h2, 3'h0, 6'(op), 1'b1);
            if (op == 3)
                for (int s = 1; s <= 4; s++)
                    cfg(3'h2, 3'(s), 6'(s + 1), 1'b1);
            for (int n = 0; n < 16; n++)
            begin
                v = 4'(n);
                internal_event[3:0] = v;
                settle(4);
                case (op)
                    3: e = (v[0] & v[1]) | (v[2] & v[3]);
                    4: e = (v[0] | v[1]) & (v[2] | v[3]);
                    5: e = |v;
                    default: e = &v;
                endcase
                `CHK("evt_out1", e, evt_out[0])
            end
        end
    endtask

    task automatic test_sources();
        logic p;
        cfg(3'h3, 3'h0, 6'h05, 1'b1);
        for (int k = 0; k < 2; k++)
        begin
            p = k[0];
            internal_event = {8{p}};
            digital_input = {4{p}};
            internal_contact = {5{p}};
            comm_input = {4{p}};
            ctrl_status = {7{p}};
            mode_key = p;
            mv1_onoff_state = p;
            mv2_duty = p ? 10'h3E8 : 10'h000;
            settle(4);
            `CHK("primary_manip_output", p, primary_manip_output)
            `CHK("secondary_manip_output", p, secondary_manip_output)
            for (int c = 0; c < 64; c++)
            begin
                cfg(3'h3, 3'h1, 6'(c), 1'b1);
                settle(6);
                `CHK("evt_out2", (c == 1) || (p && defined_src(c)),
                    evt_out[1])
            end
        end
    endtask

    task automatic test_tp();
        int steps;
        int per;
        mv1_onoff_mode = 1'b0;
        mv1_duty = 10'h12C;
        for (int u = 0; u < 4; u++)
        begin
            tp_unit_select_1 = 2'(u);
            steps = (u == 0) ? 1000 : (u == 1) ? 500 : (u == 2) ? 250 : 100;
            per = steps * TICK;
            settle(per);
            count_clr = 1'b1;
            settle(1);
            count_clr = 1'b0;
            settle(per);
            `CHK("on_count", 16'(300 * steps / 1000 * TICK), on_count)
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #400us;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        settle(5);
        `CHK("outputs in reset", 7'h00, {ctrl_out, evt_out,
            primary_manip_output, secondary_manip_output})
        settle(1);
        rst_n = 1'b1;
        test_defaults();
        test_refusals();
        test_bitfunc();
        test_sources();
        test_tp();
        give_verdict();
    end
endmodule
